/* shared/clock_ctrl_regs.vh */
// register map, field layout, reset values and timing counts of the clock control block
`ifndef CLOCK_CTRL_REGS_VH
`define CLOCK_CTRL_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define REG_FUSE_OFS        8'h00
`define REG_PRESCALE_OFS    8'h04
`define REG_SLEEP_OFS       8'h08
`define REG_STATUS_OFS      8'h0c

// ----------------------------------------------------------------------
// fuse register fields
// ----------------------------------------------------------------------
`define FUSE_SEL_LSB        0
`define FUSE_SEL_MSB        3
`define FUSE_SUT_LSB        4
`define FUSE_SUT_MSB        5
`define FUSE_DIV8_BIT       6
`define FUSE_SEL_RESET      4'h2
`define FUSE_SUT_RESET      2'h2
`define FUSE_DIV8_RESET     1'h0

// ----------------------------------------------------------------------
// prescaler and sleep register fields
// ----------------------------------------------------------------------
`define PRESCALE_MSB        3
`define PRESCALE_DIV8       4'h3
`define PRESCALE_DIV1       4'h0
`define SLEEP_MODE_MSB      2
`define SLEEP_GO_BIT        3

// ----------------------------------------------------------------------
// sleep mode codes
// ----------------------------------------------------------------------
`define MODE_IDLE           3'h0
`define MODE_CONV_QUIET     3'h1
`define MODE_POWER_DOWN     3'h2
`define MODE_POWER_SAVE     3'h3
`define MODE_STANDBY        3'h6

// ----------------------------------------------------------------------
// decoded clock sources
// ----------------------------------------------------------------------
`define SRC_XTAL            3'h0
`define SRC_LFXTAL          3'h1
`define SRC_RC              3'h2
`define SRC_EXT             3'h3
`define SRC_NONE            3'h4

// ----------------------------------------------------------------------
// start-up time fuse codes and watchdog oscillator counts
// ----------------------------------------------------------------------
`define SUT_NO_DELAY        2'h0
`define SUT_SHORT_DELAY     2'h1
`define RESET_SHORT_CYCLES  4096
`define RESET_LONG_CYCLES   65536
`define TIMER_W             17

`endif

/* src/startup_timer.v */
// counts a given number of ticks after a start pulse and flags the end
`timescale 1ns/1ps
module startup_timer #(
   parameter W = 17
) (
   // clock and reset
   input  wire         hclk,
   input  wire         hresetn,
   // control
   input  wire         start,
   input  wire [W-1:0] length,
   input  wire         tick,
   // result
   output reg          done_q
);
   reg [W-1:0] cnt_q;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q  <= {W{1'b0}};
         done_q <= 1'b0;
      end else if (start) begin
         cnt_q  <= length;
         done_q <= (length == {W{1'b0}});
      end else if (!done_q && tick) begin
         cnt_q  <= cnt_q - {{(W-1){1'b0}}, 1'b1};
         done_q <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
      end
   end
endmodule

/* src/sys_prescaler.v */
// divides the system clock enable by a power of two
`timescale 1ns/1ps
module sys_prescaler (
   // clock and reset
   input  wire       hclk,
   input  wire       hresetn,
   // control
   input  wire       run,
   input  wire [3:0] log2_div,
   // output enable pulse
   output reg        tick_q
);
   reg  [7:0] cnt_q;
   wire [7:0] mask;

   // all ones in the low log2_div bits
   assign mask = ~(8'hff << log2_div);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q  <= 8'h00;
         tick_q <= 1'b0;
      end else if (!run) begin
         cnt_q  <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_q + 8'h01;
         tick_q <= ((cnt_q & mask) == mask);
      end
   end
endmodule

/* src/clock_source_distribution.v */
// clock source selection, start-up timing and per-domain clock gating
// What this block does
// - select codes 1111..1000 pick crystal/resonator, 0111..0100 low-frequency crystal
// - 0010 picks internal RC, 0000 external clock; 0011 and 0001 pick nothing
// - a fuse bit holding one is unprogrammed, zero is programmed
// - wake from power-down or power-save waits selected source start-up before running
// - after reset an extra delay is counted on watchdog oscillator ticks
// - that reset delay is 0, 4096 or 65536 watchdog oscillator cycles (start-up 00, 01, otherwise)
// - fuses reset to select 0010, start-up 10, divide-by-eight programmed
// - delivered settings start the system clock divided by eight
// - each sleep mode stops the clocks of domains it does not use
// - core clock stops completely while the core is halted
// - peripheral clock feeds timers, serial ports and interrupt logic
// - asynchronous interrupt detection is enabled whenever the peripheral clock stops
// - serial start-condition detector runs asynchronously while peripheral clock stops
// - program-memory clock runs whenever the core clock runs
// - asynchronous timer domain is clocked from the external timer source
// - asynchronous timer domain keeps running only in idle, converter-quiet and power-save sleep
// - display outputs stay driven from the asynchronous domain in idle, converter-quiet and power-save sleep
// - converter domain stays active in converter-quiet sleep while core and peripheral clocks stop
// - a data write pending at power-down continues until finished
// - after such a write the oscillator keeps running through power-down
// - programmed divide-by-eight fuse loads divide by eight into the prescaler when start-up ends
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "clock_ctrl_regs.vh"
module clock_source_distribution #(
   parameter RESET_SHORT_CYCLES = `RESET_SHORT_CYCLES,
   parameter RESET_LONG_CYCLES  = `RESET_LONG_CYCLES,
   parameter XTAL_WAKE_CYCLES   = 16384,
   parameter LFXTAL_WAKE_CYCLES = 32768,
   parameter RC_WAKE_CYCLES     = 6,
   parameter EXT_WAKE_CYCLES    = 6
) (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // oscillator and watchdog ticks
   input  wire        xtal_tick,
   input  wire        lfxtal_tick,
   input  wire        rc_tick,
   input  wire        ext_clk_tick,
   input  wire        wdt_osc_tick,
   // events
   input  wire        wake_event,
   input  wire        nv_write_busy,
   // domain clock enables
   output reg         core_clock_en,
   output reg         peripheral_clock_en,
   output reg         program_memory_clock_en,
   output reg         async_timer_clock_en,
   output reg         converter_clock_en,
   // sleep side controls
   output reg         osc_run,
   output reg         async_irq_detect_en,
   output reg         usi_start_async_en,
   output reg         lcd_drive_en,
   output reg         nv_write_clock_en
);
   // ----------------------------------------------------------------------
   // state codes
   // ----------------------------------------------------------------------
   localparam ST_INIT   = 3'h0;
   localparam ST_RST_TO = 3'h1;
   localparam ST_OSC    = 3'h2;
   localparam ST_RUN    = 3'h3;
   localparam ST_SLEEP  = 3'h4;
   localparam ST_WAKE   = 3'h5;

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   function [2:0] decode_source;
      input [3:0] sel;
      begin
         if (sel[3])
            decode_source = `SRC_XTAL;
         else if (sel[2])
            decode_source = `SRC_LFXTAL;
         else if (sel == 4'h2)
            decode_source = `SRC_RC;
         else if (sel == 4'h0)
            decode_source = `SRC_EXT;
         else
            decode_source = `SRC_NONE;
      end
   endfunction

   function is_deep_sleep;
      input [2:0] mode;
      begin
         is_deep_sleep = (mode == `MODE_POWER_DOWN) || (mode == `MODE_POWER_SAVE);
      end
   endfunction

   // ----------------------------------------------------------------------
   // registers and wires
   // ----------------------------------------------------------------------
   reg  [3:0]            sel_q;
   reg  [1:0]            sut_q;
   reg                   div8_q;
   reg  [3:0]            prescale_q;
   reg  [2:0]            mode_q;
   reg  [2:0]            state_q;
   reg                   osc_hold_q;
   reg                   wr_pend_q;
   reg  [7:0]            wr_addr_q;
   wire                  addr_phase;
   wire                  sleep_go;
   wire [2:0]            source;
   reg                   src_tick;
   reg  [`TIMER_W-1:0]   wake_len;
   reg  [`TIMER_W-1:0]   reset_len;
   wire                  start_reset;
   wire                  start_osc;
   wire                  reset_done;
   wire                  osc_done;
   wire                  sys_tick;
   reg                   core_on;
   reg                   io_on;
   reg                   asy_on;
   reg                   adc_on;
   reg                   osc_on;
   reg  [31:0]           rd_val;

   assign source = decode_source(sel_q);

   // ----------------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------------
   assign addr_phase = hsel && htrans[1] && hready;
   assign sleep_go   = wr_pend_q && (wr_addr_q == `REG_SLEEP_OFS) && hwdata[`SLEEP_GO_BIT];

   always @* begin
      case (haddr)
         `REG_FUSE_OFS:     rd_val = {25'h0000000, div8_q, sut_q, sel_q};
         `REG_PRESCALE_OFS: rd_val = {28'h0000000, prescale_q};
         `REG_SLEEP_OFS:    rd_val = {29'h00000000, mode_q};
         `REG_STATUS_OFS:   rd_val = {17'h00000, nv_write_busy, osc_hold_q, osc_run,
                                     core_clock_en, peripheral_clock_en,
                                     async_timer_clock_en, converter_clock_en,
                                     1'b0, source, 1'b0, state_q};
         default:           rd_val = 32'h00000000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend_q <= addr_phase && hwrite;
         if (addr_phase) begin
            wr_addr_q <= haddr;
         end
         if (addr_phase && !hwrite) begin
            hrdata <= rd_val;
         end
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // fuse, prescaler and sleep mode registers
   // ----------------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_q      <= `FUSE_SEL_RESET;
         sut_q      <= `FUSE_SUT_RESET;
         div8_q     <= `FUSE_DIV8_RESET;
         prescale_q <= `PRESCALE_DIV1;
         mode_q     <= `MODE_IDLE;
      end else begin
         if (state_q == ST_OSC && osc_done) begin
            // programmed (zero) divide fuse starts at divide by eight
            prescale_q <= div8_q ? `PRESCALE_DIV1 : `PRESCALE_DIV8;
         end else if (wr_pend_q && wr_addr_q == `REG_PRESCALE_OFS) begin
            prescale_q <= (hwdata[`PRESCALE_MSB:0] > 4'h8) ? 4'h8 : hwdata[`PRESCALE_MSB:0];
         end
         if (wr_pend_q && wr_addr_q == `REG_FUSE_OFS) begin
            sel_q  <= hwdata[`FUSE_SEL_MSB:`FUSE_SEL_LSB];
            sut_q  <= hwdata[`FUSE_SUT_MSB:`FUSE_SUT_LSB];
            div8_q <= hwdata[`FUSE_DIV8_BIT];
         end
         if (wr_pend_q && wr_addr_q == `REG_SLEEP_OFS && state_q == ST_RUN) begin
            mode_q <= hwdata[`SLEEP_MODE_MSB:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // start-up lengths and source tick selection
   // ----------------------------------------------------------------------
   always @* begin
      case (sut_q)
         `SUT_NO_DELAY:    reset_len = {`TIMER_W{1'b0}};
         `SUT_SHORT_DELAY: reset_len = RESET_SHORT_CYCLES[`TIMER_W-1:0];
         default:          reset_len = RESET_LONG_CYCLES[`TIMER_W-1:0];
      endcase
   end

   always @* begin
      case (source)
         `SRC_XTAL: begin
            src_tick = xtal_tick;
            wake_len = XTAL_WAKE_CYCLES[`TIMER_W-1:0];
         end
         `SRC_LFXTAL: begin
            src_tick = lfxtal_tick;
            wake_len = LFXTAL_WAKE_CYCLES[`TIMER_W-1:0];
         end
         `SRC_RC: begin
            src_tick = rc_tick;
            wake_len = RC_WAKE_CYCLES[`TIMER_W-1:0];
         end
         `SRC_EXT: begin
            src_tick = ext_clk_tick;
            wake_len = EXT_WAKE_CYCLES[`TIMER_W-1:0];
         end
         default: begin
            // reserved code: no source, start-up never ends
            src_tick = 1'b0;
            wake_len = {`TIMER_W{1'b1}};
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // timers
   // ----------------------------------------------------------------------
   assign start_reset = (state_q == ST_INIT);
   assign start_osc   = (state_q == ST_RST_TO && reset_done) ||
                        (state_q == ST_SLEEP && wake_event && is_deep_sleep(mode_q));

   // reset delay runs on the watchdog oscillator
   startup_timer #(.W(`TIMER_W)) u_reset_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (start_reset),
      .length  (reset_len),
      .tick    (wdt_osc_tick),
      .done_q  (reset_done)
   );

   // wake delay runs on the selected source
   startup_timer #(.W(`TIMER_W)) u_osc_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (start_osc),
      .length  (wake_len),
      .tick    (src_tick),
      .done_q  (osc_done)
   );

   sys_prescaler u_prescaler (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .run      (state_q == ST_RUN),
      .log2_div (prescale_q),
      .tick_q   (sys_tick)
   );

   // ----------------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q    <= ST_INIT;
         osc_hold_q <= 1'b0;
      end else begin
         case (state_q)
            ST_INIT: begin
               state_q <= ST_RST_TO;
            end
            ST_RST_TO: begin
               if (reset_done) begin
                  state_q <= ST_OSC;
               end
            end
            ST_OSC: begin
               if (osc_done) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (sleep_go) begin
                  state_q    <= ST_SLEEP;
                  // write in flight: oscillator must not stop
                  osc_hold_q <= (hwdata[`SLEEP_MODE_MSB:0] == `MODE_POWER_DOWN) &&
                                nv_write_busy;
               end
            end
            ST_SLEEP: begin
               if (wake_event) begin
                  osc_hold_q <= 1'b0;
                  state_q    <= is_deep_sleep(mode_q) ? ST_WAKE : ST_RUN;
               end
            end
            ST_WAKE: begin
               if (osc_done) begin
                  state_q <= ST_RUN;
               end
            end
            default: begin
               state_q <= ST_INIT;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // per-mode domain plan
   // ----------------------------------------------------------------------
   always @* begin
      core_on = 1'b0;
      io_on   = 1'b0;
      adc_on  = 1'b0;
      asy_on  = 1'b0;
      osc_on  = 1'b1;
      case (state_q)
         ST_RUN: begin
            core_on = 1'b1;
            io_on   = 1'b1;
            adc_on  = 1'b1;
            asy_on  = 1'b1;
         end
         ST_SLEEP: begin
            case (mode_q)
               `MODE_IDLE: begin
                  io_on  = 1'b1;
                  adc_on = 1'b1;
                  asy_on = 1'b1;
               end
               `MODE_CONV_QUIET: begin
                  adc_on = 1'b1;
                  asy_on = 1'b1;
               end
               `MODE_POWER_DOWN: begin
                  osc_on = osc_hold_q || nv_write_busy;
               end
               `MODE_POWER_SAVE: begin
                  asy_on = 1'b1;
                  osc_on = nv_write_busy;
               end
               default: begin
                  osc_on = 1'b1;
               end
            endcase
         end
         ST_WAKE: begin
            asy_on = is_deep_sleep(mode_q) && (mode_q == `MODE_POWER_SAVE);
         end
         default: begin
            osc_on = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // registered domain enables
   // ----------------------------------------------------------------------
   // gates only move on hclk edges, so gated clocks see whole cycles
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_clock_en           <= 1'b0;
         peripheral_clock_en     <= 1'b0;
         program_memory_clock_en <= 1'b0;
         async_timer_clock_en    <= 1'b0;
         converter_clock_en      <= 1'b0;
         osc_run                 <= 1'b1;
         async_irq_detect_en     <= 1'b1;
         usi_start_async_en      <= 1'b1;
         lcd_drive_en            <= 1'b0;
         nv_write_clock_en       <= 1'b0;
      end else begin
         core_clock_en           <= core_on && sys_tick;
         program_memory_clock_en <= core_on && sys_tick;
         peripheral_clock_en     <= io_on && (sys_tick || state_q != ST_RUN);
         converter_clock_en      <= adc_on && (sys_tick || state_q != ST_RUN);
         async_timer_clock_en    <= asy_on;
         lcd_drive_en            <= asy_on;
         async_irq_detect_en     <= !io_on;
         usi_start_async_en      <= !io_on;
         osc_run                 <= osc_on;
         nv_write_clock_en       <= nv_write_busy;
      end
   end
endmodule

/* tb/osc_model.sv */
// free-running oscillator and watchdog tick sources
`timescale 1ns/1ps
module osc_model #(
   parameter int XD = 2,
   parameter int LD = 5,
   parameter int RD = 3,
   parameter int ED = 4,
   parameter int WD = 7
) (
   // clock and reset
   input  wire  hclk,
   input  wire  hresetn,
   // one-cycle ticks
   output logic xtal_tick,
   output logic lfxtal_tick,
   output logic rc_tick,
   output logic ext_clk_tick,
   output logic wdt_osc_tick
);
   int c;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) c <= 0;
      else c <= c + 1;
   end
   // distinct periods so each source is told apart by its timing
   assign xtal_tick    = (c % XD) == 0;
   assign lfxtal_tick  = (c % LD) == 0;
   assign rc_tick      = (c % RD) == 0;
   assign ext_clk_tick = (c % ED) == 0;
   assign wdt_osc_tick = (c % WD) == 0;
endmodule

/* tb/clock_source_distribution_asserts.sv */
// port checker for the clock gating block
`timescale 1ns/1ps
module clock_source_distribution_asserts #(
   parameter RESET_LONG_CYCLES = 16
) (
   input wire hclk,
   input wire hresetn,
   input wire wdt_osc_tick,
   input wire nv_write_busy,
   input wire core_clock_en,
   input wire peripheral_clock_en,
   input wire program_memory_clock_en,
   input wire async_timer_clock_en,
   input wire converter_clock_en,
   input wire osc_run,
   input wire async_irq_detect_en,
   input wire usi_start_async_en,
   input wire lcd_drive_en,
   input wire nv_write_clock_en
);
   // watchdog ticks seen since reset release
   reg [16:0] ticks_q;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ticks_q <= 17'h0;
      else if (wdt_osc_tick && ticks_q != 17'h1ffff) ticks_q <= ticks_q + 17'h1;
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_per_level;
      peripheral_clock_en [*3];
   endsequence
   sequence s_conv_level;
      converter_clock_en [*3];
   endsequence
   a_flash_core_same: assert property (program_memory_clock_en == core_clock_en)
      else $error("program memory enable differs from core enable");
   a_lcd_async_same: assert property (lcd_drive_en == async_timer_clock_en)
      else $error("lcd drive differs from async timer enable");
   a_usi_irq_same: assert property (usi_start_async_en == async_irq_detect_en)
      else $error("serial start detect differs from async irq detect");
   a_run_domains: assert property (core_clock_en |-> !async_irq_detect_en && async_timer_clock_en)
      else $error("wrong async controls while core runs");
   a_reset_delay: assert property (core_clock_en |-> ticks_q >= RESET_LONG_CYCLES)
      else $error("core clock before reset delay elapsed");
   a_div_eight: assert property (core_clock_en |=> !core_clock_en [*7])
      else $error("core pulses closer than eight cycles");
   a_idle_core_off: assert property (s_per_level |-> !$past(core_clock_en) && $past(converter_clock_en))
      else $error("idle level with core running or converter off");
   a_quiet_core_off: assert property (s_conv_level |-> !$past(core_clock_en))
      else $error("converter level while core runs");
   a_nv_follow: assert property (nv_write_busy |=> nv_write_clock_en)
      else $error("data write clock not kept");
   a_nv_osc_on: assert property (nv_write_clock_en |-> osc_run)
      else $error("oscillator stopped during data write");
endmodule
bind clock_source_distribution clock_source_distribution_asserts #(
   .RESET_LONG_CYCLES(RESET_LONG_CYCLES)
) i_chk (
   .hclk(hclk), .hresetn(hresetn), .wdt_osc_tick(wdt_osc_tick),
   .nv_write_busy(nv_write_busy), .core_clock_en(core_clock_en),
   .peripheral_clock_en(peripheral_clock_en),
   .program_memory_clock_en(program_memory_clock_en),
   .async_timer_clock_en(async_timer_clock_en), .converter_clock_en(converter_clock_en),
   .osc_run(osc_run), .async_irq_detect_en(async_irq_detect_en),
   .usi_start_async_en(usi_start_async_en), .lcd_drive_en(lcd_drive_en),
   .nv_write_clock_en(nv_write_clock_en)
);

/* tb/clock_source_distribution_bench.sv */
// self-checking bench for the clock gating block
`timescale 1ns/1ps
`include "clock_ctrl_regs.vh"
module clock_source_distribution_bench;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, wake_event = 0, nv_write_busy = 0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, xt, lt, rt, et, wt;
   wire         cce, pce, pmce, ace, cve, osc, aie, universal_serial_interface, lcd, nve;
   integer      bad_count = 0, comparisons = 0, cyc = 0;
   always #5 hclk = ~hclk;
   clock_source_distribution #(
      .RESET_SHORT_CYCLES(8), .RESET_LONG_CYCLES(16),
      .XTAL_WAKE_CYCLES(8), .LFXTAL_WAKE_CYCLES(8)
   ) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .xtal_tick(xt), .lfxtal_tick(lt), .rc_tick(rt), .ext_clk_tick(et),
      .wdt_osc_tick(wt), .wake_event(wake_event), .nv_write_busy(nv_write_busy),
      .core_clock_en(cce), .peripheral_clock_en(pce), .program_memory_clock_en(pmce),
      .async_timer_clock_en(ace), .converter_clock_en(cve), .osc_run(osc),
      .async_irq_detect_en(aie), .usi_start_async_en(universal_serial_interface), .lcd_drive_en(lcd),
      .nv_write_clock_en(nve)
   );
   osc_model i_osc (
      .hclk(hclk), .hresetn(hresetn), .xtal_tick(xt), .lfxtal_tick(lt),
      .rc_tick(rt), .ext_clk_tick(et), .wdt_osc_tick(wt)
   );
   // ------------------------------------------------------------
   // bus and compare helpers
   // ------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r & m, e);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task wake;
      wake_event <= 1'b1;
      @(posedge hclk);
      wake_event <= 1'b0;
   endtask
   task wait_run;
      logic [31:0] r;
      integer n;
      n = 0;
      r = 32'h0;
      while (r[2:0] !== 3'h3 && n < 100) begin
         bus(1'b0, `REG_STATUS_OFS, 32'h0, r);
         n = n + 1;
      end
      chk({29'h0, r[2:0]}, 32'h3);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_defaults;
      rd(`REG_FUSE_OFS, 32'hffffffff, 32'h22);
      rd(`REG_PRESCALE_OFS, 32'hf, 32'h3);
      rd(`REG_STATUS_OFS, 32'h70, 32'h20);
      rd(8'h10, 32'hffffffff, 32'h0);
      $display("test defaults done");
   endtask
   task t_sources;
      logic [23:0] sels, srcs;
      integer i;
      sels = 24'hf87420;
      srcs = 24'h001123;
      for (i = 0; i < 6; i++) begin
         wr(`REG_FUSE_OFS, {26'h0, 2'h2, sels[23-4*i -: 4]});
         wr(`REG_SLEEP_OFS, {28'h0, 1'b1, `MODE_POWER_SAVE});
         repeat (4) @(posedge hclk);
         chk({30'h0, cce, ace}, 32'h1);
         wake;
         rd(`REG_STATUS_OFS, 32'h7, 32'h5);
         wait_run;
         rd(`REG_STATUS_OFS, 32'h70, {25'h0, srcs[22-4*i -: 3], 4'h0});
      end
      $display("test sources done");
   endtask
   task t_modes;
      logic [15:0] modes;
      logic [31:0] exps;
      integer i;
      modes = 16'h0126;
      exps = 32'h1d0f0203;
      for (i = 0; i < 4; i++) begin
         // no data write is pending before any sleep request
         chk({31'h0, nv_write_busy}, 32'h0);
         wr(`REG_SLEEP_OFS, {28'h0, 1'b1, modes[14-4*i -: 3]});
         repeat (4) @(posedge hclk);
         chk({26'h0, cce, pce, cve, ace, aie, osc}, {24'h0, exps[31-8*i -: 8]});
         wake;
         wait_run;
      end
      $display("test modes done");
   endtask
   task t_nv;
      nv_write_busy <= 1'b1;
      wr(`REG_SLEEP_OFS, {28'h0, 1'b1, `MODE_POWER_DOWN});
      repeat (6) @(posedge hclk);
      nv_write_busy <= 1'b0;
      repeat (6) @(posedge hclk);
      chk({31'h0, osc}, 32'h1);
      wake;
      wait_run;
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      wait_run;
      rd(`REG_FUSE_OFS, 32'hffffffff, 32'h22);
      $display("test data write and reset done");
   endtask
   task finish_test;
      $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         finish_test;
      end
   end
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      wait_run;
      t_defaults;
      t_sources;
      t_modes;
      t_nv;
      finish_test;
   end
endmodule
